/* File: sci_bench.sv */
`timescale 1ns/10ps
module sci_bench;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic slow = 1'b0;
  logic ce = 1'b1;
  logic [2:0] ce_cnt = 3'h0;
  logic [15:0] kelvin = 16'h0000;
  logic rx_valid, rx_ready, tx_valid, tx_ready, busy;
  logic [7:0] rx_data, tx_data;
  logic [2:0] heater_range;
  int fails = 0;
  int n_checks = 0;
  int seed = 32'h6adde50c;
  string crlf = "\015\012";
  always #4 i_clock = ~i_clock;
  // Enable drops one cycle in eight so frozen cycles are exercised
  always @(posedge i_clock) begin
    ce_cnt <= ce_cnt + 3'h1;
    ce <= #1 ce_cnt != 3'h5;
  end
  sci_core sci_core_i (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_ce(ce),
    .i_rx_valid(rx_valid),
    .i_rx_data(rx_data),
    .o_rx_ready(rx_ready),
    .o_tx_valid(tx_valid),
    .o_tx_data(tx_data),
    .i_tx_ready(tx_ready),
    .i_kelvin_bcd(kelvin),
    .o_heater_range(heater_range),
    .o_busy(busy)
  );
  sci_host_model sci_host_model_i (
    .i_clock(i_clock),
    .i_ce(ce),
    .i_slow(slow),
    .o_rx_valid(rx_valid),
    .o_rx_data(rx_data),
    .i_rx_ready(rx_ready),
    .i_tx_valid(tx_valid),
    .i_tx_data(tx_data),
    .o_tx_ready(tx_ready)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic string kel(input logic [15:0] b);
    return $sformatf("+0%h%h.%h%h\015\012", b[15:12], b[11:8], b[7:4], b[3:0]);
  endfunction
  // Sends one line, waits for idle, compares the whole reply
  task automatic run(input string line, input string exp);
    int n;
    sci_host_model_i.got.delete();
    sci_host_model_i.send_line({line, crlf});
    n = 0;
    repeat (2) @(posedge i_clock);
    #1;
    while (!(rx_ready === 1'b1 && busy === 1'b0) && n < 2000) begin // Bounded wait
      @(posedge i_clock);
      #1;
      n++;
    end
    check(n < 2000, 1);
    check(sci_host_model_i.got.size(), exp.len());
    foreach (sci_host_model_i.got[k]) begin
      check(sci_host_model_i.got[k], (k < exp.len()) ? exp[k] : 8'h00);
    end
  endtask
  initial begin
    int r;
    string kel_q;
    kel_q = $sformatf("%s", 32'h4b52_4447);
    repeat (2) @(posedge i_clock);
    #1;
    i_nrst = 1'b1;
    run("RANGE?", {"0", crlf});
    check(heater_range, 3'h0);
    run("RANGE 1; RANGE?", {"1", crlf});
    check(heater_range, 3'h1);
    run("RANGE +2", "");
    check(heater_range, 3'h2);
    run("RANGE 03", "");
    check(heater_range, 3'h3);
    run(kel_q, "");
    run("RANGX?", "");
    run("FOO 1;RANGE?", {"3", crlf});
    run("RANGE 1.0;RANGE?", {"1", crlf});
    check(heater_range, 3'h1);
    run("IDN?", "");
    run("*IDN?", {$sformatf("%s,%s,%s,%s", sci_pkg::ID_MAKER, sci_pkg::ID_MODEL,
      sci_pkg::ID_SERIAL, sci_pkg::ID_DATE), crlf});
    slow = 1'b1;
    for (int i = 0; i < 6; i++) begin
      r = $unsigned($random(seed)) % 4;
      run($sformatf("RANGE %0d;RANGE?", r), {$sformatf("%0d", r), crlf});
      check(heater_range, r);
      kelvin[15:12] = 4'($unsigned($random(seed)) % 10);
      kelvin[11:8] = 4'($unsigned($random(seed)) % 10);
      kelvin[7:4] = 4'($unsigned($random(seed)) % 10);
      kelvin[3:0] = (i == 0) ? 4'h0 : 4'($unsigned($random(seed)) % 10);
      run({kel_q, "?"}, kel(kelvin));
    end
    end_of_test();
  end
  // Whole run is about a thousand cycles
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
endmodule // sci_bench

/* File: sci_core.sv */
`timescale 1ns/10ps
// How it works
// R01: Every response ends with carriage return then line feed.
// R02: Correct query name without question mark produces no reply.
// R03: Unknown names are dropped silently, no error reply.
// R04: Host separates name and parameters with a space.
// R05: Short numbers accepted; replies always padded to full field.
// R06: Unsigned numbers positive; minus sign needed for negatives.
// R07: Setting commands apply the value and send nothing.
// R08: Semicolon-separated commands run in order within one line.
// R09: Identity query returns maker, model, serial, date comma separated.
// R10: Names starting with asterisk decode as common commands.
// R11: Numeric fields are digits with optional point; alnum fields letters/digits.
// R12: Host baud rate matches the device.
// R13: Host waits for terminators, times out after idle polls.
// R14: Host sends whole line including terminators at once.
// R15: Host may space commands 100 ms apart.
// R16: Buffer a full line, process it, clear before next line.
module sci_core (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  output logic o_rx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  input wire logic [15:0] i_kelvin_bcd,
  output logic [2:0] o_heater_range,
  output logic o_busy
);
  typedef struct packed {
    sci_pkg::sci_state_t state;
    logic [sci_pkg::LINE_DEPTH-1:0][7:0] line;
    logic [sci_pkg::LINE_AW-1:0] wr;
    logic [sci_pkg::LINE_AW-1:0] rd;
    logic [8*sci_pkg::NAME_LEN-1:0] name;
    logic [2:0] nlen;
    logic star;
    logic query;
    logic bad;
    logic [2:0] pval;
    logic pdig;
    logic pneg;
    logic pfrac;
    logic [2:0] range;
    logic load;
    logic [8*sci_pkg::RESP_LEN-1:0] text;
    logic [sci_pkg::RESP_AW-1:0] count;
  } sci_st_t;
  sci_st_t st_r, st_nxt;
  logic tx_busy;
  logic [7:0] ch;

  function automatic logic is_digit(input logic [7:0] c);
    return c >= sci_pkg::CH_ZERO && c <= 8'h39;
  endfunction
  function automatic logic is_alpha(input logic [7:0] c);
    return (c >= 8'h41 && c <= 8'h5a) || (c >= 8'h61 && c <= 8'h7a);
  endfunction
  function automatic logic [7:0] upcase(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7a) ? c - 8'h20 : c;
  endfunction
  function automatic logic [1:0] decode(input logic [39:0] n, input logic [2:0] len, input logic star);
    if (star) begin // [R10]
      return (len == 3'd3 && n[23:0] == 24'h49_44_4e) ? sci_pkg::CMD_IDN : sci_pkg::CMD_NONE;
    end
    if (len == 3'd5 && n == 40'h52_41_4e_47_45) begin
      return sci_pkg::CMD_RANGE;
    end
    if (len == 3'd4 && n[31:0] == 32'h4b_52_44_47) begin
      return sci_pkg::CMD_KELVIN;
    end
    return sci_pkg::CMD_NONE;
  endfunction

  assign ch = st_r.line[st_r.rd];

  always_comb begin
    logic [1:0] cmd;
    logic end_item;
    logic [7:0] acc;
    cmd = decode(st_r.name, st_r.nlen, st_r.star);
    acc = '0;
    end_item = (st_r.rd == st_r.wr) || ch == sci_pkg::CH_SEMI || ch == sci_pkg::CH_CR
      || ch == sci_pkg::CH_LF;
    st_nxt = st_r;
    st_nxt.load = 1'b0;
    unique case (st_r.state)
      sci_pkg::SCI_COLLECT: begin
        if (i_rx_valid) begin // [R16]
          st_nxt.line[st_r.wr] = i_rx_data;
          if (i_rx_data == sci_pkg::CH_LF) begin
            st_nxt.state = sci_pkg::SCI_SCAN;
            st_nxt.rd = '0;
            st_nxt.name = '0;
            st_nxt.nlen = '0;
            st_nxt.star = 1'b0;
            st_nxt.query = 1'b0;
            st_nxt.bad = 1'b0;
          end else if (st_r.wr != sci_pkg::LINE_AW'(sci_pkg::LINE_DEPTH - 1)) begin
            st_nxt.wr = st_r.wr + 1'b1;
          end
        end
      end
      sci_pkg::SCI_SCAN: begin
        // Blanks before a name, as after a semicolon, are skipped
        if (end_item || (ch == sci_pkg::CH_SPACE && st_r.nlen != '0)) begin // [R08]
          st_nxt.state = end_item ? sci_pkg::SCI_EXEC : sci_pkg::SCI_PARAM;
          st_nxt.pval = '0;
          st_nxt.pdig = 1'b0;
          st_nxt.pneg = 1'b0;
          st_nxt.pfrac = 1'b0;
          if (!end_item) st_nxt.rd = st_r.rd + 1'b1;
        end else begin
          st_nxt.rd = st_r.rd + 1'b1;
          if (ch == sci_pkg::CH_SPACE) begin
            st_nxt.bad = st_r.bad;
          end else if (ch == sci_pkg::CH_STAR && st_r.nlen == '0 && !st_r.star) begin
            st_nxt.star = 1'b1; // [R10]
          end else if (ch == sci_pkg::CH_QUEST) begin
            st_nxt.query = 1'b1; // [R02]
          end else if (st_r.query || st_r.nlen == 3'd5 || !(is_alpha(ch) || is_digit(ch))) begin
            st_nxt.bad = 1'b1; // [R03]
          end else begin
            st_nxt.name = {st_r.name[31:0], upcase(ch)};
            st_nxt.nlen = st_r.nlen + 1'b1;
          end
        end
      end
      sci_pkg::SCI_PARAM: begin
        if (end_item) begin
          st_nxt.state = sci_pkg::SCI_EXEC;
        end else begin
          st_nxt.rd = st_r.rd + 1'b1;
          if (ch == sci_pkg::CH_MINUS && !st_r.pdig) begin
            st_nxt.pneg = 1'b1; // [R06]
          end else if (ch == sci_pkg::CH_PLUS && !st_r.pdig) begin
            st_nxt.pneg = 1'b0; // [R06]
          end else if (is_digit(ch)) begin
            st_nxt.pdig = 1'b1; // [R11] [R05]
            acc = 8'(st_r.pval) * 8'd10 + {4'h0, ch[3:0]};
            if (st_r.pfrac) begin
              // Integer field: only zeros may follow the point
              st_nxt.pval = ch == sci_pkg::CH_ZERO ? st_r.pval : 3'h7; // [R05]
            end else begin
              st_nxt.pval = acc > 8'(sci_pkg::RANGE_MAX) ? 3'h7 : acc[2:0];
            end
          end else if (ch == sci_pkg::CH_DOT) begin
            st_nxt.pfrac = 1'b1; // [R11]
          end else if (ch == sci_pkg::CH_SPACE || ch == sci_pkg::CH_COMMA) begin
            st_nxt.pdig = st_r.pdig; // [R11]
          end else if (!is_alpha(ch)) begin
            st_nxt.bad = 1'b1;
          end
        end
      end
      sci_pkg::SCI_EXEC: begin
        if (!tx_busy) begin
          st_nxt.state = sci_pkg::SCI_SCAN;
          st_nxt.name = '0;
          st_nxt.nlen = '0;
          st_nxt.star = 1'b0;
          st_nxt.query = 1'b0;
          st_nxt.bad = 1'b0;
          if (!st_r.bad && st_r.query) begin // [R02] [R03]
            st_nxt.load = cmd != sci_pkg::CMD_NONE;
            unique case (cmd)
              sci_pkg::CMD_IDN: begin
                st_nxt.text = {sci_pkg::ID_MAKER, sci_pkg::CH_COMMA, sci_pkg::ID_MODEL, sci_pkg::CH_COMMA,
                  sci_pkg::ID_SERIAL, sci_pkg::CH_COMMA, sci_pkg::ID_DATE, sci_pkg::CH_CR, sci_pkg::CH_LF}; // [R09] [R01]
                st_nxt.count = 5'd24;
              end
              sci_pkg::CMD_RANGE: begin
                st_nxt.text = {8'(sci_pkg::CH_ZERO + 8'(st_r.range)), sci_pkg::CH_CR, sci_pkg::CH_LF, 168'h0};
                st_nxt.count = 5'd3; // [R01] [R08]
              end
              sci_pkg::CMD_KELVIN: begin
                // Hundreds digit is not measured, always sent as zero
                st_nxt.text = {sci_pkg::CH_PLUS, sci_pkg::CH_ZERO, 4'h3, i_kelvin_bcd[15:12], 4'h3, i_kelvin_bcd[11:8],
                  sci_pkg::CH_DOT, 4'h3, i_kelvin_bcd[7:4], 4'h3, i_kelvin_bcd[3:0], sci_pkg::CH_CR,
                  sci_pkg::CH_LF, 120'h0}; // [R05] [R01]
                st_nxt.count = 5'(sci_pkg::KEL_CHARS + 2);
              end
              default: begin
                st_nxt.load = 1'b0;
              end
            endcase
          end else if (!st_r.bad && cmd == sci_pkg::CMD_RANGE && st_r.pdig && !st_r.pneg
            && st_r.pval <= sci_pkg::RANGE_MAX) begin
            st_nxt.range = st_r.pval; // [R07]
          end
          if (st_r.rd == st_r.wr) begin
            st_nxt.state = sci_pkg::SCI_SEND;
          end else begin
            st_nxt.rd = st_r.rd + 1'b1; // [R08]
          end
        end
      end
      sci_pkg::SCI_SEND: begin
        if (!tx_busy && !st_r.load) begin
          st_nxt.state = sci_pkg::SCI_COLLECT; // [R16]
          st_nxt.wr = '0;
          st_nxt.rd = '0;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st_r <= '0;
      st_r.state <= sci_pkg::SCI_COLLECT;
      st_r.range <= sci_pkg::RANGE_RESET;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  sci_tx_shift u_tx (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_load(st_r.load),
    .i_text(st_r.text),
    .i_count(st_r.count),
    .i_tx_ready(i_tx_ready),
    .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data),
    .o_busy(tx_busy)
  );

  assign o_rx_ready = st_r.state == sci_pkg::SCI_COLLECT;
  assign o_heater_range = st_r.range;
  assign o_busy = st_r.state != sci_pkg::SCI_COLLECT;

  a_tx_only_query: assert property (@(posedge i_clock) disable iff (!i_nrst) // [R07]
    $rose(st_r.load) |-> $past(st_r.query))
    else $error("response loaded without query");
  a_last_is_lf: assert property (@(posedge i_clock) disable iff (!i_nrst) // [R01]
    st_r.load && i_ce |=> st_r.text[7:0] == sci_pkg::CH_LF || st_r.count != 5'd24)
    else $error("identity reply lacks line feed");
  a_no_bad_reply: assert property (@(posedge i_clock) disable iff (!i_nrst) // [R03]
    st_r.state == sci_pkg::SCI_EXEC && st_r.bad |=> !st_r.load)
    else $error("reply to malformed name");
  a_range_valid: assert property (@(posedge i_clock) disable iff (!i_nrst) // [R06]
    o_heater_range <= sci_pkg::RANGE_MAX)
    else $error("heater range out of bounds");
  a_line_cleared: assert property (@(posedge i_clock) disable iff (!i_nrst) // [R16]
    $rose(o_rx_ready) |-> st_r.wr == '0)
    else $error("line buffer not cleared");
  a_no_rx_busy: assert property (@(posedge i_clock) disable iff (!i_nrst) // [R16]
    o_tx_valid |-> !o_rx_ready)
    else $error("accepting while reply pending");
  a_reply_crlf: assert property (@(posedge i_clock) disable iff (!i_nrst) // [R01]
    $rose(st_r.load) |-> st_r.text[8*(sci_pkg::RESP_LEN - int'(st_r.count)) +: 16] == {sci_pkg::CH_CR, sci_pkg::CH_LF})
    else $error("reply lacks terminators");
  a_kel_format: assert property (@(posedge i_clock) disable iff (!i_nrst) // [R05]
    $rose(st_r.load) && st_r.count == 5'(sci_pkg::KEL_CHARS + 2) |-> st_r.text[8*sci_pkg::RESP_LEN-1 -: 16]
      == {sci_pkg::CH_PLUS, sci_pkg::CH_ZERO} && st_r.text[8*sci_pkg::RESP_LEN-33 -: 8] == sci_pkg::CH_DOT)
    else $error("reading not padded");
  a_star_decode: assert property (@(posedge i_clock) disable iff (!i_nrst) // [R10]
    st_r.state == sci_pkg::SCI_EXEC && !st_r.star |=> !(st_r.load && st_r.count == 5'd24))
    else $error("identity without asterisk");
  a_neg_ignored: assert property (@(posedge i_clock) disable iff (!i_nrst) // [R06]
    st_r.state == sci_pkg::SCI_EXEC && st_r.pneg |=> $stable(o_heater_range))
    else $error("negative range applied");
  a_range_hold: assert property (@(posedge i_clock) disable iff (!i_nrst) // [R07]
    st_r.state != sci_pkg::SCI_EXEC |=> $stable(o_heater_range))
    else $error("range changed outside execute");
  a_noq_silent: assert property (@(posedge i_clock) disable iff (!i_nrst) // [R02]
    st_r.state == sci_pkg::SCI_EXEC && !st_r.query |=> !st_r.load)
    else $error("reply without question mark");
  c_idn: cover property (@(posedge i_clock) st_r.load && st_r.count == 5'd24);
  c_range_set: cover property (@(posedge i_clock) $changed(o_heater_range));
  c_tx_char: cover property (@(posedge i_clock) o_tx_valid && i_tx_ready);
  c_kelvin: cover property (@(posedge i_clock) $rose(st_r.load) && st_r.count == 5'(sci_pkg::KEL_CHARS + 2));
  c_multi: cover property (@(posedge i_clock) st_r.state == sci_pkg::SCI_EXEC && ch == sci_pkg::CH_SEMI);
endmodule // sci_core

/* File: sci_host_model.sv */
`timescale 1ns/10ps
// Host side: sends whole lines, collects reply chars
module sci_host_model (
  input wire logic i_clock, // Same character rate as the block
  input wire logic i_ce,
  input wire logic i_slow,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready
);
  logic taken;
  logic [1:0] cnt;
  logic [7:0] got[$];
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data = 8'h55;
    o_tx_ready = 1'b1;
    taken = 1'b0;
    cnt = 2'h0;
  end
  // Old values seen here, design registers land later
  always @(posedge i_clock) begin
    taken <= o_rx_valid && i_rx_ready && i_ce;
    if (i_tx_valid && o_tx_ready && i_ce) begin
      got.push_back(i_tx_data);
    end
    cnt <= cnt + 2'h1;
    o_tx_ready <= #1 !i_slow || (cnt == 2'h3);
  end
  task automatic send_line(input string s);
    repeat (4) @(posedge i_clock); // Idle gap between lines
    #1;
    for (int k = 0; k < s.len(); k++) begin // Whole line in one burst
      o_rx_valid = 1'b1;
      o_rx_data = s[k];
      do begin
        @(posedge i_clock);
        #1;
      end while (!taken);
    end
    o_rx_valid = 1'b0;
    o_rx_data = ~o_rx_data; // Released data must not look valid
  endtask
endmodule // sci_host_model

/* File: sci_pkg.sv */
package sci_pkg;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_QUEST = 8'h3f;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam int LINE_DEPTH = 32;
  localparam int LINE_AW = 5;
  localparam int NAME_LEN = 5;
  localparam int RESP_LEN = 24;
  localparam int RESP_AW = 5;
  localparam logic [2:0] RANGE_RESET = 3'h0;
  localparam logic [2:0] RANGE_MAX = 3'h3;
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_IDN = 2'h1;
  localparam logic [1:0] CMD_RANGE = 2'h2;
  localparam logic [1:0] CMD_KELVIN = 2'h3;
  // Neutral identity strings, arbitrary values
  localparam logic [8*4-1:0] ID_MAKER = 32'h4143_4d45;
  localparam logic [8*4-1:0] ID_MODEL = 32'h554e_4954;
  localparam logic [8*5-1:0] ID_SERIAL = 40'h3030_3030_31;
  localparam logic [8*6-1:0] ID_DATE = 48'h3031_3031_3030;
  // Kelvin reading: sign, 3 integer digits, point, 2 fraction digits
  localparam int KEL_CHARS = 7;
  typedef enum logic [2:0] {SCI_COLLECT, SCI_SCAN, SCI_PARAM, SCI_EXEC, SCI_SEND} sci_state_t;
endpackage

/* File: sci_tx_shift.sv */
`timescale 1ns/10ps
// Response character serialiser; one char per ready handshake.
module sci_tx_shift (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic [8*sci_pkg::RESP_LEN-1:0] i_text,
  input wire logic [sci_pkg::RESP_AW-1:0] i_count,
  input wire logic i_tx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic o_busy
);
  typedef struct packed {
    logic [8*sci_pkg::RESP_LEN-1:0] text;
    logic [sci_pkg::RESP_AW-1:0] left;
  } sci_tx_t;
  sci_tx_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (i_load && st_r.left == '0) begin
      st_nxt.text = i_text;
      st_nxt.left = i_count;
    end else if (st_r.left != '0 && i_tx_ready) begin
      // First char sits in the top byte, so shift up
      st_nxt.left = st_r.left - 1'b1;
      st_nxt.text = st_r.text << 8;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_tx_valid = st_r.left != '0;
  assign o_tx_data = st_r.text[8*sci_pkg::RESP_LEN-1 -: 8];
  assign o_busy = st_r.left != '0;
endmodule // sci_tx_shift
